// >>> hdl/register_map_access.sv
// Notes on behaviour
// - converter end-of-scan check runs only after scan codes 0 or 1 with enable set.
// - the check conversion runs with the converter in bipolar mode.
// - a check result below FFFh sets the full-scale fault flag in diag register B.
// - a switch or trace fault raises one balancing flag, for that cell only.
// - protocol-violating transactions are rejected and reported in status 1; framing errors also in status 2.
// - a rejected transaction gets no reserved-address or bitfield handling.
// - user space is 0x00 to 0x98; listed holes there are reserved.
// - addresses 0x99 to 0xFF are reserved.
// - a clean access to a reserved address raises no interface error.
// - writes to reserved addresses are dropped; reads return zero.
// - block readback returns zero for reserved addresses and skips none.
// - error checks cover all 16 data bits, unused ones included.
// - unused bitfields store nothing and read zero.
// - the spare bit and spare nibble store and read back, with no effect.
// - a write to a busy register is ignored and sets the reject flag.
`include "regmap_regs.svh"

module register_map_access import regmap_pkg::*; #(
	parameter logic [15:0] VERSION_CODE = 16'h1234, // arbitrary value
	parameter int CELLS = 14
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// transaction from the link layer
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_block,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_count,
	input wire logic [15:0] req_wdata,
	input wire logic req_pec_err,
	input wire logic req_frame_err,
	output logic req_ready,
	// answer to the link layer
	output logic rsp_valid,
	output logic rsp_rejected,
	output logic rsp_last,
	output logic [15:0] rsp_rdata,
	// internal processes
	input wire logic cfg_busy,
	input wire logic scan_done,
	input wire logic open_diag_done,
	input wire logic [CELLS-1:0] odd_hi,
	input wire logic [CELLS-1:0] even_hi,
	// converter check
	output logic adc_check_req,
	output logic adc_bipolar,
	input wire logic adc_result_valid,
	input wire logic [11:0] adc_result
);
	bus_state_t bus_state, next_bus_state;
	chk_state_t chk_state, next_chk_state;
	logic [7:0] blk_addr, next_blk_addr, blk_left, next_blk_left;
	logic [15:0] chain, next_chain;
	logic [15:0] devcfg1, next_devcfg1;
	logic [15:0] devcfg2, next_devcfg2;
	logic [15:0] scanctl, next_scanctl;
	logic [15:0] stat1, next_stat1;
	logic [15:0] stat2, next_stat2;
	logic [15:0] diag_b, next_diag_b;
	logic [CELLS-1:0] balsw_flags, balsw_clr;
	logic next_req_ready, next_rsp_valid, next_rsp_rejected, next_rsp_last;
	logic [15:0] next_rsp_rdata;
	logic next_adc_check_req, next_adc_bipolar, adcfs_set;
	logic [2:0] scan_config_select;
	logic adc_scale_check_enable, take_req, req_err, clean_wr, wr_st2_clr, busy_wr;

	assign scan_config_select = scanctl[2:0];
	assign adc_scale_check_enable = scanctl[`RM_BIT_SCALE_EN];
	assign take_req = req_valid && req_ready;
	assign req_err = req_pec_err || req_frame_err;
	assign clean_wr = take_req && !req_err && req_write && !req_block;
	assign wr_st2_clr = clean_wr && req_addr == `RM_ADDR_STAT2;
	assign busy_wr = clean_wr && cfg_busy && (req_addr == `RM_ADDR_DEVCFG1
		|| req_addr == `RM_ADDR_DEVCFG2 || req_addr == `RM_ADDR_SCANCTL);

	// reserved: holes in user space and everything above it
	function automatic logic is_reserved(input logic [7:0] a);
		is_reserved = (a > `RM_USER_TOP)
			|| (a >= `RM_RSV_A_LO && a <= `RM_RSV_A_HI)
			|| (a == `RM_RSV_B)
			|| (a >= `RM_RSV_C_LO && a <= `RM_RSV_C_HI);
	endfunction

	// read view; unimplemented and reserved words read zero
	function automatic logic [15:0] read_word(input logic [7:0] a);
		logic [15:0] w, st1_view, diag_a_view;
		w = `RM_RESET_WORD;
		st1_view = stat1;
		st1_view[`RM_BIT_STAT1_DIAG_B] = |diag_b;
		diag_a_view = `RM_RESET_WORD;
		diag_a_view[`RM_BIT_DIAG_A_BALSW] = |balsw_flags;
		st1_view[`RM_BIT_STAT1_DIAG_A] = |diag_a_view;
		if (!is_reserved(a)) begin
			case (a)
				`RM_ADDR_VERSION: w = VERSION_CODE;
				`RM_ADDR_CHAIN: w = chain;
				`RM_ADDR_STAT1: w = st1_view;
				`RM_ADDR_STAT2: w = stat2;
				`RM_ADDR_DIAG_A: w = diag_a_view;
				`RM_ADDR_DIAG_B: w = diag_b;
				`RM_ADDR_BALSW: w = 16'(balsw_flags) & `RM_MASK_BALSW;
				`RM_ADDR_DEVCFG1: w = devcfg1;
				`RM_ADDR_DEVCFG2: w = devcfg2;
				`RM_ADDR_SCANCTL: w = scanctl;
				default: w = `RM_RESET_WORD;
			endcase
		end
		return w;
	endfunction

	// one sticky flag per cell, cleared by writing one to its bit
	genvar gi;
	generate
		for (gi = 0; gi < CELLS; gi++) begin : g_cell
			assign balsw_clr[gi] = clean_wr && req_addr == `RM_ADDR_BALSW && req_wdata[gi];
			balsw_cell_flag u_flag (
				.core_clk(core_clk),
				.srst(srst),
				.odd_hi(odd_hi[gi]),
				.even_hi(even_hi[gi]),
				.diag_done(open_diag_done),
				.clr(balsw_clr[gi]),
				.flag(balsw_flags[gi])
			);
		end
	endgenerate

	// end-of-scan converter check sequencing
	always_comb begin
		next_chk_state = chk_state;
		next_adc_check_req = adc_check_req;
		next_adc_bipolar = adc_bipolar;
		adcfs_set = 1'b0;
		case (chk_state)
			CHK_IDLE: begin
				if (scan_done && adc_scale_check_enable
					&& scan_config_select <= `RM_SCAN_ADC_MAX) begin
					next_chk_state = CHK_CONV;
					next_adc_check_req = 1'b1;
					next_adc_bipolar = 1'b1;
				end
			end
			CHK_CONV: begin
				if (adc_result_valid) begin
					adcfs_set = adc_result < `RM_ADC_FULLSCALE;
					next_chk_state = CHK_IDLE;
					next_adc_check_req = 1'b0;
					next_adc_bipolar = 1'b0;
				end
			end
			default: begin
				next_chk_state = CHK_IDLE;
				next_adc_check_req = 1'b0;
				next_adc_bipolar = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			chk_state <= CHK_IDLE;
			adc_check_req <= 1'b0;
			adc_bipolar <= 1'b0;
		end else begin
			chk_state <= next_chk_state;
			adc_check_req <= next_adc_check_req;
			adc_bipolar <= next_adc_bipolar;
		end
	end

	// transaction handling; flag sets are applied after clears so a set wins
	always_comb begin
		next_bus_state = bus_state;
		next_blk_addr = blk_addr;
		next_blk_left = blk_left;
		next_chain = chain;
		next_devcfg1 = devcfg1;
		next_devcfg2 = devcfg2;
		next_scanctl = scanctl;
		next_stat1 = stat1;
		next_stat2 = stat2;
		next_diag_b = diag_b;
		next_rsp_valid = 1'b0;
		next_rsp_rejected = 1'b0;
		next_rsp_last = 1'b0;
		next_rsp_rdata = `RM_RESET_WORD;
		case (bus_state)
			BUS_IDLE: begin
				if (take_req) begin
					next_rsp_valid = 1'b1;
					next_rsp_last = 1'b1;
					if (req_err) begin
						next_rsp_rejected = 1'b1;
					end else if (!req_write) begin
						next_rsp_rdata = read_word(req_addr);
						if (req_block && req_count > 8'h01) begin
							next_rsp_last = 1'b0;
							next_bus_state = BUS_BLOCK;
							next_blk_addr = req_addr + 8'h01;
							next_blk_left = req_count - 8'h01;
						end
					end else if (!is_reserved(req_addr)) begin
						case (req_addr)
							`RM_ADDR_CHAIN: next_chain = req_wdata & `RM_MASK_CHAIN;
							`RM_ADDR_STAT1: next_stat1 = stat1 & ~req_wdata;
							`RM_ADDR_STAT2: next_stat2 = stat2 & ~req_wdata;
							`RM_ADDR_DIAG_B: next_diag_b = diag_b & ~req_wdata;
							`RM_ADDR_DEVCFG1, `RM_ADDR_DEVCFG2, `RM_ADDR_SCANCTL: begin
								if (cfg_busy) begin
									next_rsp_rejected = 1'b1;
								end else if (req_addr == `RM_ADDR_DEVCFG1) begin
									next_devcfg1 = req_wdata & `RM_MASK_DEVCFG1;
								end else if (req_addr == `RM_ADDR_DEVCFG2) begin
									next_devcfg2 = req_wdata & `RM_MASK_DEVCFG2;
								end else begin
									next_scanctl = req_wdata & `RM_MASK_SCANCTL;
								end
							end
							default: next_chain = chain;
						endcase
					end
				end
			end
			BUS_BLOCK: begin
				// every address answers in turn, reserved ones with zero
				next_rsp_valid = 1'b1;
				next_rsp_rdata = read_word(blk_addr);
				next_blk_addr = blk_addr + 8'h01;
				next_blk_left = blk_left - 8'h01;
				if (blk_left == 8'h01) begin
					next_rsp_last = 1'b1;
					next_bus_state = BUS_IDLE;
				end
			end
			default: next_bus_state = BUS_IDLE;
		endcase
		// event sets after software clears
		if (take_req && req_pec_err) begin
			next_stat1[`RM_BIT_STAT1_PEC] = 1'b1;
		end
		if (take_req && req_err) begin
			next_stat1[`RM_BIT_STAT1_INTRFC] = 1'b1;
		end
		if (take_req && req_frame_err) begin
			next_stat2[`RM_BIT_STAT2_FRAME] = 1'b1;
		end
		if (busy_wr) begin
			next_stat2[`RM_BIT_STAT2_RJCT] = 1'b1;
		end
		if (adcfs_set) begin
			next_diag_b[`RM_BIT_DIAG_B_ADCFS] = 1'b1;
		end
		next_req_ready = next_bus_state == BUS_IDLE;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			bus_state <= BUS_IDLE;
			blk_addr <= 8'h00;
			blk_left <= 8'h00;
			chain <= `RM_RESET_WORD;
			devcfg1 <= `RM_RESET_WORD;
			devcfg2 <= `RM_RESET_WORD;
			scanctl <= `RM_RESET_WORD;
			stat1 <= `RM_RESET_WORD;
			stat2 <= `RM_RESET_WORD;
			diag_b <= `RM_RESET_WORD;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rejected <= 1'b0;
			rsp_last <= 1'b0;
			rsp_rdata <= `RM_RESET_WORD;
		end else begin
			bus_state <= next_bus_state;
			blk_addr <= next_blk_addr;
			blk_left <= next_blk_left;
			chain <= next_chain;
			devcfg1 <= next_devcfg1;
			devcfg2 <= next_devcfg2;
			scanctl <= next_scanctl;
			stat1 <= next_stat1;
			stat2 <= next_stat2;
			diag_b <= next_diag_b;
			req_ready <= next_req_ready;
			rsp_valid <= next_rsp_valid;
			rsp_rejected <= next_rsp_rejected;
			rsp_last <= next_rsp_last;
			rsp_rdata <= next_rsp_rdata;
		end
	end

	// checks on the block's own behaviour
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	AST_CHK_CAUSE: assert property ($rose(adc_check_req) |-> $past(scan_done)
		&& $past(adc_scale_check_enable) && $past(scan_config_select) <= `RM_SCAN_ADC_MAX)
		else $error("converter check started without a qualifying scan");
	AST_CHK_BIPOLAR: assert property (adc_check_req |-> adc_bipolar)
		else $error("converter check not in bipolar mode");
	AST_FS_FAULT: assert property (chk_state == CHK_CONV && adc_result_valid
		&& adc_result < `RM_ADC_FULLSCALE |=> diag_b[`RM_BIT_DIAG_B_ADCFS])
		else $error("full-scale fault not flagged");
	AST_BALSW_QUIET: assert property (open_diag_done && odd_hi == '0
		&& even_hi == '0 && balsw_clr == '0 |=> $stable(balsw_flags))
		else $error("balancing flag changed without a high result");
	AST_PROTO_REJECT: assert property (take_req && req_err |=>
		rsp_valid && rsp_rejected && stat1[`RM_BIT_STAT1_INTRFC])
		else $error("protocol error not rejected and reported");
	AST_PROTO_NOSTORE: assert property (take_req && req_err |=>
		$stable(devcfg1) && $stable(scanctl) && $stable(chain) && rsp_rdata == '0)
		else $error("rejected transaction touched the registers");
	AST_RSV_READ: assert property (take_req && !req_err && !req_write
		&& is_reserved(req_addr) |=> rsp_valid && !rsp_rejected && rsp_rdata == '0)
		else $error("reserved read not zero or flagged");
	AST_RSV_WRITE: assert property (clean_wr && is_reserved(req_addr) |=>
		!rsp_rejected && $stable(stat2) && $stable(devcfg1))
		else $error("reserved write raised an error or stored");
	AST_BUSY_REJECT: assert property (busy_wr |=> rsp_rejected
		&& stat2[`RM_BIT_STAT2_RJCT] && $stable(devcfg1) && $stable(devcfg2) && $stable(scanctl))
		else $error("busy write not rejected");
	AST_BLOCK_SEQ: assert property (bus_state == BUS_BLOCK |=>
		rsp_valid && rsp_rdata == read_word($past(blk_addr)))
		else $error("block readback skipped or lost a word");
	AST_STICKY: assert property (stat2[`RM_BIT_STAT2_RJCT] && !wr_st2_clr |=>
		stat2[`RM_BIT_STAT2_RJCT])
		else $error("reject flag dropped without a clear");
	COV_BLOCK_READ: cover property (take_req && req_block && req_count > 8'h02);
	COV_BUSY_WRITE: cover property (clean_wr && cfg_busy);
	COV_FS_FAULT: cover property (adcfs_set);
	COV_PROTO_ERR: cover property (take_req && req_pec_err && is_reserved(req_addr));
endmodule

// >>> hdl/regmap_regs.svh
`ifndef REGMAP_REGS_SVH
`define REGMAP_REGS_SVH

// register word addresses
`define RM_ADDR_VERSION 8'h00
`define RM_ADDR_CHAIN 8'h01
`define RM_ADDR_STAT1 8'h02
`define RM_ADDR_STAT2 8'h03
`define RM_ADDR_STAT3 8'h04
`define RM_ADDR_DIAG_A 8'h05
`define RM_ADDR_DIAG_B 8'h06
`define RM_ADDR_BALSW 8'h12
`define RM_ADDR_DEVCFG1 8'h14
`define RM_ADDR_DEVCFG2 8'h15
`define RM_ADDR_SCANCTL 8'h40

// reserved address ranges
`define RM_USER_TOP 8'h98
`define RM_RSV_A_LO 8'h2C
`define RM_RSV_A_HI 8'h2F
`define RM_RSV_B 8'h46
`define RM_RSV_C_LO 8'h84
`define RM_RSV_C_HI 8'h8B

// storage masks: bits outside a mask are unused and read zero
`define RM_MASK_CHAIN 16'h9FFF
`define RM_MASK_DEVCFG1 16'hFFFF
`define RM_MASK_DEVCFG2 16'hEF00
`define RM_MASK_SCANCTL 16'h000F
`define RM_MASK_BALSW 16'h3FFF

// bit positions
`define RM_BIT_STAT1_PEC 5
`define RM_BIT_STAT1_INTRFC 4
`define RM_BIT_STAT1_DIAG_B 1
`define RM_BIT_STAT1_DIAG_A 0
`define RM_BIT_STAT2_FRAME 7
`define RM_BIT_STAT2_RJCT 0
`define RM_BIT_DIAG_A_BALSW 0
`define RM_BIT_DIAG_B_ADCFS 2
`define RM_BIT_SPARE_BIT 3
`define RM_LSB_SPARE_NIB 8
`define RM_BIT_SCALE_EN 3

// full-scale expectation and scan codes that use the converter
`define RM_ADC_FULLSCALE 12'hFFF
`define RM_SCAN_ADC_MAX 3'h1
`define RM_RESET_WORD 16'h0000

`endif

// >>> hdl/regmap_pkg.sv
package regmap_pkg;
	// link-side sequencing
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_BLOCK = 2'b10
	} bus_state_t;
	// end-of-scan converter check
	typedef enum logic [1:0] {
		CHK_IDLE = 2'b01,
		CHK_CONV = 2'b10
	} chk_state_t;
endpackage

// >>> hdl/balsw_cell_flag.sv
// one sticky balancing-switch fault flag for a single cell
module balsw_cell_flag (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// diagnostic results for this cell
	input wire logic odd_hi,
	input wire logic even_hi,
	input wire logic diag_done,
	// software clear and flag
	input wire logic clr,
	output logic flag
);
	logic next_flag;

	// a switch or trace fault reads high in only its own cell, so one flag rises
	always_comb begin
		next_flag = flag & ~clr;
		if (diag_done && (odd_hi || even_hi)) begin
			next_flag = 1'b1; // set wins over clear
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end
endmodule

// >>> testbench/host_link.sv
// host side of the register link: holds one request until the device takes it
module host_link (
	// clock and handshake
	input wire logic core_clk,
	input wire logic req_ready,
	// request towards the device
	output logic req_valid,
	output logic req_write,
	output logic req_block,
	output logic [7:0] req_addr,
	output logic [7:0] req_count,
	output logic [15:0] req_wdata,
	output logic req_pec_err,
	output logic req_frame_err
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet link at time zero
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_block = 1'b0;
		req_addr = 8'h00;
		req_count = 8'h00;
		req_wdata = 16'h0000;
		req_pec_err = 1'b0;
		req_frame_err = 1'b0;
	end

	// entered at a rising edge, returns at the edge that took the request
	task automatic send(input logic w, b, input logic [7:0] a, n, input logic [15:0] d,
			input logic pe, fe);
		req_valid <= 1'b1;
		req_write <= w;
		req_block <= b;
		req_addr <= a;
		req_count <= n;
		req_wdata <= d; // all sixteen bits go out
		req_pec_err <= pe;
		req_frame_err <= fe;
		@(negedge core_clk);
		while (req_ready !== 1'b1)
			@(negedge core_clk);
		@(posedge core_clk);
	endtask

	// address and data lines flip on release, so a stale word can never pass for a fresh one
	task automatic idle();
		req_valid <= 1'b0;
		req_addr <= ~req_addr;
		req_wdata <= ~req_wdata;
		@(posedge core_clk);
	endtask
endmodule

// >>> testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] VER = 16'h5A3C; // arbitrary value
	logic core_clk;
	logic srst = 1'b1;
	logic cfg_busy = 1'b0;
	logic scan_done = 1'b0;
	logic open_diag_done = 1'b0;
	logic adc_result_valid = 1'b0;
	logic [11:0] adc_result = 12'h000;
	logic [13:0] odd_hi = 14'h0000;
	logic [13:0] even_hi = 14'h0000;
	logic req_valid, req_write, req_block, req_pec_err, req_frame_err, req_ready;
	logic [7:0] req_addr, req_count;
	logic [15:0] req_wdata, rsp_rdata, c1;
	logic rsp_valid, rsp_rejected, rsp_last, adc_check_req, adc_bipolar, e;
	logic [31:0] rnd = 32'h32a7_6e98;
	logic [17:0] exp_q[$];
	logic [7:0] rsv [7] = '{8'h2C, 8'h2F, 8'h46, 8'h84, 8'h8B, 8'h99, 8'hFF};
	logic [3:0] scfg [6] = '{4'h8, 4'h9, 4'hA, 4'hF, 4'h0, 4'h1};
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;

	register_map_access #(.VERSION_CODE(VER)) uut (
		.core_clk, .srst, .req_valid, .req_write, .req_block, .req_addr, .req_count,
		.req_wdata, .req_pec_err, .req_frame_err, .req_ready, .rsp_valid, .rsp_rejected,
		.rsp_last, .rsp_rdata, .cfg_busy, .scan_done, .open_diag_done, .odd_hi, .even_hi,
		.adc_check_req, .adc_bipolar, .adc_result_valid, .adc_result
	);

	host_link hl (
		.core_clk, .req_ready, .req_valid, .req_write, .req_block, .req_addr, .req_count,
		.req_wdata, .req_pec_err, .req_frame_err
	);

	// 50 MHz
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic fail(input string m);
		error_cnt++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask

	task automatic check(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1)
			fail(m);
	endtask

	task automatic summarize();
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// a note is {rejected, last, data}; writes always answer with zero data
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic pe, fe, rj);
		exp_q.push_back({rj, 1'b1, 16'h0000});
		hl.send(1'b1, 1'b0, a, 8'h00, d, pe, fe);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] x);
		exp_q.push_back({2'b01, x});
		hl.send(1'b0, 1'b0, a, 8'h00, rnd[15:0], 1'b0, 1'b0);
	endtask

	// answers return in request order, so the oldest note is the one to compare
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (srst === 1'b0 && rsp_valid === 1'b1) begin
			check(exp_q.size() > 0, "answer without request");
			if (exp_q.size() > 0)
				check({rsp_rejected, rsp_last, rsp_rdata} === exp_q.pop_front(),
					$sformatf("answer %h", rsp_rdata));
		end
		if (cyc == 6000) begin
			fail("timeout");
			summarize();
		end
	end

	initial begin
		repeat (12) @(posedge core_clk);
		check(req_ready === 1'b0 && rsp_valid === 1'b0, "outputs in reset");
		srst <= 1'b0;
		@(negedge core_clk);
		check(req_ready === 1'b0, "ready too early");
		@(posedge core_clk);
		@(negedge core_clk);
		check(req_ready === 1'b1, "ready missing");
		@(posedge core_clk);
		// reserved places: writes vanish, reads give zero, no error raised
		// a normal host leaves them alone; they are written here on purpose
		foreach (rsv[i]) begin
			rnd = lfsr(rnd);
			wr(rsv[i], rnd[15:0], 1'b0, 1'b0, 1'b0);
			rd(rsv[i], 16'h0000);
		end
		// unused bits drop, spare fields keep what was written
		rnd = lfsr(rnd);
		c1 = rnd[15:0] & 16'h9FFF;
		wr(8'h01, rnd[15:0], 1'b0, 1'b0, 1'b0);
		rd(8'h01, c1);
		wr(8'h14, rnd[31:16], 1'b0, 1'b0, 1'b0);
		rd(8'h14, rnd[31:16]);
		wr(8'h15, 16'hFFFF, 1'b0, 1'b0, 1'b0);
		rd(8'h15, 16'hEF00);
		// protocol faults refuse the transfer, even on a reserved place
		wr(8'h14, ~rnd[31:16], 1'b1, 1'b0, 1'b1);
		rd(8'h14, rnd[31:16]);
		rd(8'h02, 16'h0030);
		wr(8'h2C, rnd[15:0], 1'b1, 1'b1, 1'b1);
		rd(8'h03, 16'h0080);
		wr(8'h02, 16'hFFFF, 1'b0, 1'b0, 1'b0);
		wr(8'h03, 16'hFFFF, 1'b0, 1'b0, 1'b0);
		rd(8'h02, 16'h0000);
		rd(8'h03, 16'h0000);
		// writes while the configuration is in use are refused
		cfg_busy <= 1'b1;
		wr(8'h40, 16'h0009, 1'b0, 1'b0, 1'b1);
		wr(8'h15, 16'h0000, 1'b0, 1'b0, 1'b1);
		cfg_busy <= 1'b0;
		rd(8'h40, 16'h0000);
		rd(8'h15, 16'hEF00);
		rd(8'h03, 16'h0001);
		wr(8'h03, 16'hFFFF, 1'b0, 1'b0, 1'b0);
		// block read wraps past the top and skips nothing
		exp_q.push_back({2'b00, 16'h0000});
		exp_q.push_back({2'b00, 16'h0000});
		exp_q.push_back({2'b00, VER});
		exp_q.push_back({2'b01, c1});
		hl.send(1'b0, 1'b1, 8'hFE, 8'h04, rnd[15:0], 1'b0, 1'b0);
		hl.idle();
		@(negedge core_clk);
		check(req_ready === 1'b0, "ready during block");
		@(posedge core_clk);
		rd(8'h2D, 16'h0000);
		// converter check only for codes 0 and 1 with the enable set
		for (int k = 0; k < 6; k++) begin
			wr(8'h40, {12'h000, scfg[k]}, 1'b0, 1'b0, 1'b0); // written while idle
			rd(8'h40, {12'h000, scfg[k]});
			hl.idle();
			scan_done <= 1'b1;
			@(posedge core_clk);
			scan_done <= 1'b0;
			@(posedge core_clk);
			@(negedge core_clk);
			e = scfg[k][3] && scfg[k][2:0] <= 3'h1;
			check(adc_check_req === e && adc_bipolar === e, "check start");
			@(posedge core_clk);
			rnd = lfsr(rnd);
			adc_result_valid <= 1'b1;
			adc_result <= (k == 0) ? rnd[11:0] & 12'hFFE : 12'hFFF;
			@(posedge core_clk);
			adc_result_valid <= 1'b0;
			@(posedge core_clk);
			@(negedge core_clk);
			check(adc_check_req === 1'b0 && adc_bipolar === 1'b0, "check stuck");
			@(posedge core_clk);
			rd(8'h06, (k == 0) ? 16'h0004 : 16'h0000);
			rd(8'h02, (k == 0) ? 16'h0002 : 16'h0000);
			wr(8'h06, 16'hFFFF, 1'b0, 1'b0, 1'b0);
		end
		// one switch fault seen by both halves gives one flag
		hl.idle();
		odd_hi <= 14'h0008;
		even_hi <= 14'h0008;
		open_diag_done <= 1'b1;
		@(posedge core_clk);
		open_diag_done <= 1'b0;
		odd_hi <= 14'h2001;
		even_hi <= 14'h0000;
		rd(8'h12, 16'h0008);
		rd(8'h05, 16'h0001);
		rd(8'h02, 16'h0001);
		wr(8'h12, 16'hFFFF, 1'b0, 1'b0, 1'b0);
		rd(8'h12, 16'h0000);
		// a diagnostic with no high result must leave every flag down
		odd_hi <= 14'h0000;
		open_diag_done <= 1'b1;
		hl.idle();
		open_diag_done <= 1'b0;
		rd(8'h12, 16'h0000);
		hl.idle();
		repeat (4) @(posedge core_clk);
		check(exp_q.size() == 0, "answers missing");
		summarize();
	end
endmodule
